// ### common/txsw_consts.svh
`ifndef TXSW_CONSTS_SVH
`define TXSW_CONSTS_SVH
// Status word field positions
`define TXSW_OWN_BIT 31
`define TXSW_RSV30_BIT 30
`define TXSW_TDR_HI 29
`define TXSW_TDR_LO 16
`define TXSW_ES_BIT 15
`define TXSW_TO_BIT 14
`define TXSW_MBZ_BIT 13
`define TXSW_LE_BIT 12
`define TXSW_LO_BIT 11
`define TXSW_NC_BIT 10
`define TXSW_LC_BIT 9
`define TXSW_EC_BIT 8
`define TXSW_HF_BIT 7
`define TXSW_CC_HI 6
`define TXSW_CC_LO 3
`define TXSW_TN_BIT 2
`define TXSW_UF_BIT 1
`define TXSW_DE_BIT 0
// Collision limit before abort
`define TXSW_COLL_LIMIT 5'h10
// Operating select value for internal loopback
`define TXSW_OM_LOOP 2'h1
// Register offsets (byte addresses)
`define TXSW_REG_WORD 4'h0
`define TXSW_REG_STATUS 4'h4
`define TXSW_REG_MASK 4'h8
`define TXSW_REG_CTRL 4'hc
// Reset values
`define TXSW_RST_WORD 32'h0000_0000
`define TXSW_RST_MASK 3'h0
`define TXSW_RST_OM 2'h0
`endif

// ### common/txsw_pkg.sv
`default_nettype none
package txsw_pkg;
	typedef enum logic [3:0] {
		TXSW_IDLE = 4'h1,
		TXSW_RUN = 4'h2,
		TXSW_SUSP = 4'h4,
		TXSW_STOP = 4'h8
	} txsw_proc_t;
endpackage
`default_nettype wire

// ### verilog/txsw_writeback.sv
`include "txsw_consts.svh"
`default_nettype none
// Operation
// - Clear ownership once descriptor finished
// - Write 14-bit reflectometer count
// - Error summary ORs eight error flags
// - Babble sets flag, event, stops process
// - Bit 13 always written zero
// - Chain fault on bad mid-chain descriptor
// - Chain fault suspends, raises transmit event
// - Carrier loss flag, meaningless in loopback
// - No-carrier flag, meaningless in loopback
// - Late collision abort sets flag
// - Sixteen collisions abort, set excess flag
// - Missing heartbeat sets heartbeat flag
// - Four-bit collision tally reported
// - Translation fault suspends, raises event
// - FIFO underrun truncates, suspends, raises event
// - Busy channel wait sets deferred flag
module txsw_writeback (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Frame control from descriptor engine
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic desc_owned,
	input wire logic buf_zero_len,
	input wire logic [1:0] payload_type_code,
	input wire logic first_segment_mark,
	input wire logic last_segment_mark,
	input wire logic desc_fetch,
	input wire logic virtual_buffer_sel,
	// Line events
	input wire logic ev_defer,
	input wire logic ev_collision,
	input wire logic ev_late_coll,
	input wire logic ev_carrier_lost,
	input wire logic ev_no_carrier,
	input wire logic ev_no_heartbeat,
	input wire logic ev_underrun,
	input wire logic ev_xlate_fail,
	input wire logic ev_babble,
	input wire logic [13:0] reflect_in,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Results
	output logic [31:0] tx_status_word,
	output logic word_valid,
	output logic frame_abort,
	output logic proc_suspended,
	output logic proc_stopped,
	output logic irq
);

	typedef struct packed {
		txsw_pkg::txsw_proc_t proc;
		logic in_chain;
		logic [4:0] coll;
		logic [13:0] cable_reflect_count;
		logic de;
		logic hf;
		logic ec;
		logic lc;
		logic nc;
		logic lo;
		logic le;
		logic tn;
		logic uf;
		logic to;
		logic susp;
		logic stopd;
		logic [31:0] word;
		logic valid;
		logic abort;
		logic [2:0] status;
		logic [2:0] mask;
		logic [1:0] operating_select;
		logic [31:0] rdata;
		logic irq;
	} txsw_state_t;

	txsw_state_t st;
	txsw_state_t next_st;

	////////////////////////////////////////////////////////////////////
	// Assemble the status word from frame flags
	function automatic logic [31:0] build_word(input txsw_state_t s,
		input logic in_loop);
		logic [31:0] w;
		logic es;
		w = 32'h0000_0000;
		// Summary follows the bits as written, so loopback drops carrier
		es = s.uf | s.tn | s.ec | s.lc | (s.nc & ~in_loop);
		es = es | (s.lo & ~in_loop) | s.le | s.to;
		w[`TXSW_OWN_BIT] = 1'b0;
		w[`TXSW_RSV30_BIT] = 1'b0;
		w[`TXSW_TDR_HI:`TXSW_TDR_LO] = s.cable_reflect_count;
		w[`TXSW_ES_BIT] = es;
		w[`TXSW_TO_BIT] = s.to;
		w[`TXSW_MBZ_BIT] = 1'b0;
		w[`TXSW_LE_BIT] = s.le;
		// Carrier flags are forced low in loopback since they mean nothing
		w[`TXSW_LO_BIT] = s.lo & ~in_loop;
		w[`TXSW_NC_BIT] = s.nc & ~in_loop;
		w[`TXSW_LC_BIT] = s.lc;
		w[`TXSW_EC_BIT] = s.ec;
		w[`TXSW_HF_BIT] = s.hf;
		w[`TXSW_CC_HI:`TXSW_CC_LO] = s.coll[3:0];
		w[`TXSW_TN_BIT] = s.tn;
		w[`TXSW_UF_BIT] = s.uf;
		w[`TXSW_DE_BIT] = s.de;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		logic chain_bad;
		logic stop_ev;
		logic susp_ev;
		logic done;
		logic loop;
		txsw_state_t f;
		chain_bad = 1'b0;
		stop_ev = 1'b0;
		susp_ev = 1'b0;
		done = 1'b0;
		loop = 1'b0;
		f = st;
		next_st = st;
		f.valid = 1'b0;
		f.abort = 1'b0;
		loop = (st.operating_select == `TXSW_OM_LOOP);
		if (frame_start) begin
			f.coll = 5'h00;
			f.cable_reflect_count = 14'h0000;
			{f.de, f.hf, f.ec, f.lc, f.nc} = 5'h00;
			{f.lo, f.le, f.tn, f.uf, f.to} = 5'h00;
			f.proc = txsw_pkg::TXSW_RUN;
		end
		if (desc_fetch) begin
			// Mid-chain descriptor checks and segment ordering
			if (st.in_chain && (!desc_owned || buf_zero_len ||
				payload_type_code != 2'h0 || first_segment_mark))
				chain_bad = 1'b1;
			if (!st.in_chain && !first_segment_mark)
				chain_bad = 1'b1;
			f.in_chain = !last_segment_mark;
		end
		if (ev_defer)
			f.de = 1'b1;
		if (ev_no_heartbeat)
			f.hf = 1'b1;
		if (ev_carrier_lost)
			f.lo = 1'b1;
		if (ev_no_carrier)
			f.nc = 1'b1;
		if (ev_collision && st.coll < `TXSW_COLL_LIMIT) begin
			f.coll = st.coll + 5'h01;
			if (st.coll == `TXSW_COLL_LIMIT - 5'h01) begin
				f.ec = 1'b1;
				f.cable_reflect_count = reflect_in;
				done = 1'b1;
			end
		end
		if (ev_late_coll) begin
			f.lc = 1'b1;
			done = 1'b1;
		end
		if (ev_underrun) begin
			f.uf = 1'b1;
			susp_ev = 1'b1;
			done = 1'b1;
		end
		if (ev_xlate_fail && virtual_buffer_sel) begin
			f.tn = 1'b1;
			susp_ev = 1'b1;
			done = 1'b1;
		end
		if (chain_bad) begin
			f.le = 1'b1;
			susp_ev = 1'b1;
			done = 1'b1;
			f.in_chain = 1'b0;
		end
		if (ev_babble) begin
			f.to = 1'b1;
			stop_ev = 1'b1;
			done = 1'b1;
		end
		if (frame_end)
			done = 1'b1;
		if (done) begin
			f.word = build_word(f, loop);
			f.valid = 1'b1;
			f.abort = f.ec | f.lc | f.uf | f.tn | f.le | f.to;
			f.in_chain = f.in_chain & ~f.abort;
		end
		if (stop_ev)
			f.proc = txsw_pkg::TXSW_STOP;
		else if (susp_ev)
			f.proc = txsw_pkg::TXSW_SUSP;
		else if (done)
			f.proc = txsw_pkg::TXSW_IDLE;
		// Process flags are registered so the outputs leave flops directly
		f.susp = (f.proc == txsw_pkg::TXSW_SUSP);
		f.stopd = (f.proc == txsw_pkg::TXSW_STOP);
		// Register writes; hardware set wins over write-one-clear
		if (reg_wr) begin
			case (reg_addr)
			`TXSW_REG_STATUS: f.status = st.status & ~reg_wdata[2:0];
			`TXSW_REG_MASK: f.mask = reg_wdata[2:0];
			`TXSW_REG_CTRL: f.operating_select = reg_wdata[1:0];
			default: f.status = f.status;
			endcase
		end
		f.status[0] = f.status[0] | stop_ev;
		f.status[1] = f.status[1] | susp_ev;
		f.status[2] = f.status[2] | done;
		f.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
			`TXSW_REG_WORD: f.rdata = st.word;
			`TXSW_REG_STATUS: f.rdata = {29'h0, st.status};
			`TXSW_REG_MASK: f.rdata = {29'h0, st.mask};
			`TXSW_REG_CTRL: f.rdata = {26'h0, st.proc, st.operating_select};
			default: f.rdata = 32'h0000_0000;
			endcase
		end
		f.irq = |(f.status & f.mask);
		if (clk_en)
			next_st = f;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.proc <= txsw_pkg::TXSW_IDLE;
			st.word <= `TXSW_RST_WORD;
			st.mask <= `TXSW_RST_MASK;
			st.operating_select <= `TXSW_RST_OM;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign tx_status_word = st.word;
	assign word_valid = st.valid;
	assign frame_abort = st.abort;
	assign proc_suspended = st.susp;
	assign proc_stopped = st.stopd;
	assign irq = st.irq;

	////////////////////////////////////////////////////////////////////
	a_word_fixed_zero: assert property (@(posedge core_clk) disable iff (rst)
		word_valid |-> !tx_status_word[31] && !tx_status_word[30]
		&& !tx_status_word[13])
		else $error("reserved or own bit set in status word");
	a_summary_or: assert property (@(posedge core_clk) disable iff (rst)
		word_valid |-> tx_status_word[15] == |{tx_status_word[14],
		tx_status_word[12:8], tx_status_word[2:1]})
		else $error("error summary mismatch");
	a_babble_stops: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_babble |=> proc_stopped && tx_status_word[14]
		&& st.status[0])
		else $error("babble did not stop process");
	a_underrun_susp: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_underrun && !ev_babble |=> proc_suspended
		&& tx_status_word[1] && frame_abort)
		else $error("underrun did not suspend");
	a_xlate_susp: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_xlate_fail && virtual_buffer_sel && !ev_babble
		|=> proc_suspended && st.status[1])
		else $error("translation fault did not suspend");
	a_chain_fault: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && desc_fetch && st.in_chain && !desc_owned
		|=> tx_status_word[12] && st.status[1])
		else $error("chain fault not flagged");
	a_excess_coll: assert property (@(posedge core_clk) disable iff (rst)
		word_valid && tx_status_word[8] |-> st.coll == 5'h10)
		else $error("excess flag without sixteen collisions");
	a_loop_carrier: assert property (@(posedge core_clk) disable iff (rst)
		word_valid && $past(st.operating_select) == 2'h1
		|-> tx_status_word[11:10] == 2'h0)
		else $error("carrier flags set in loopback");
	a_defer_flag: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_defer && frame_end && !frame_start
		|=> tx_status_word[0])
		else $error("deferred flag missing");
	a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
		irq == |(st.status & st.mask))
		else $error("interrupt does not follow status and mask");

	////////////////////////////////////////////////////////////////////
	// Per-flag checks; all but a_start_clears, a_coll_ceiling and a_abort_summary need the frame not restarted in that cycle
	a_tdr_capture: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_collision && st.coll == 5'h0f && !frame_start
		|=> tx_status_word[29:16] == $past(reflect_in))
		else $error("reflectometer count not captured");

	a_late_coll: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_late_coll && !frame_start
		|=> word_valid && tx_status_word[9] && frame_abort)
		else $error("late collision not reported");

	a_heartbeat: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_no_heartbeat && frame_end && !frame_start
		|=> tx_status_word[7])
		else $error("heartbeat flag missing");

	a_start_clears: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && frame_start && !ev_collision
		|=> st.coll == 5'h00)
		else $error("collision tally not cleared");

	a_coll_ceiling: assert property (@(posedge core_clk) disable iff (rst)
		st.coll <= 5'h10)
		else $error("collision tally past limit");

	a_carrier_lost: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_carrier_lost && frame_end && !frame_start
		&& st.operating_select != 2'h1 |=> tx_status_word[11])
		else $error("carrier loss flag missing");

	a_no_carrier: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && ev_no_carrier && frame_end && !frame_start
		&& st.operating_select != 2'h1 |=> tx_status_word[10])
		else $error("no carrier flag missing");

	a_abort_summary: assert property (@(posedge core_clk) disable iff (rst)
		frame_abort |-> tx_status_word[15])
		else $error("abort without error summary");

	// The status word only moves when a new word is announced
	a_word_stable: assert property (@(posedge core_clk) disable iff (rst)
		!word_valid |-> $stable(tx_status_word))
		else $error("status word changed without valid");

	a_freeze_hold: assert property (@(posedge core_clk) disable iff (rst)
		!clk_en |=> $stable(st))
		else $error("state moved while clock enable low");

	////////////////////////////////////////////////////////////////////
	// Register port
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero without read");

	a_rd_word: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == 4'h0
		|=> reg_rdata == $past(tx_status_word))
		else $error("word read back wrong");

	a_mask_write: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == 4'h8
		|=> st.mask == $past(reg_wdata[2:0]))
		else $error("mask write lost");

endmodule
`default_nettype wire

// ### testbench/txsw_host_model.sv
`default_nettype none
module txsw_host_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Written status word
	input wire logic word_valid,
	input wire logic [31:0] tx_status_word,
	// Host view of the shared word
	output logic [31:0] host_copy,
	output logic host_owns
);
timeunit 1ns;
timeprecision 1ps;
// Host may reuse a descriptor only once the engine gave it back
assign host_owns = !host_copy[31];
always_ff @(posedge core_clk or posedge rst) begin
	if (rst) begin
		host_copy <= 32'h8000_0000;
	end else if (word_valid) begin
		host_copy <= tx_status_word;
	end
end
endmodule
`default_nettype wire

// ### testbench/tb.sv
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 1ps;
logic core_clk = 0;
logic rst = 1;
logic vsel = 0;
logic ce = 1;
logic dfetch = 0;
logic rw = 0;
logic rr = 0;
logic [10:0] ev = '0;
logic [5:0] dsc = '0;
logic [3:0] ra = '0;
logic [13:0] refl = '0;
logic [31:0] wd = '0;
logic [31:0] rdv, rdata, word, hcopy;
logic wv, fa, psus, pstop, irq, howns;
int errors = 0;
int tests_run = 0;
always #4 core_clk = ~core_clk;
txsw_writeback u_dut (.core_clk(core_clk), .rst(rst), .clk_en(ce),
	.frame_start(ev[9]), .frame_end(ev[10]), .desc_owned(dsc[5]),
	.buf_zero_len(dsc[4]), .payload_type_code(dsc[3:2]),
	.first_segment_mark(dsc[1]), .last_segment_mark(dsc[0]),
	.desc_fetch(dfetch), .virtual_buffer_sel(vsel), .ev_defer(ev[0]),
	.ev_collision(ev[1]), .ev_late_coll(ev[2]), .ev_carrier_lost(ev[3]),
	.ev_no_carrier(ev[4]), .ev_no_heartbeat(ev[5]), .ev_underrun(ev[6]),
	.ev_xlate_fail(ev[7]), .ev_babble(ev[8]), .reflect_in(refl),
	.reg_addr(ra), .reg_wdata(wd), .reg_wr(rw), .reg_rd(rr),
	.reg_rdata(rdata), .tx_status_word(word), .word_valid(wv),
	.frame_abort(fa), .proc_suspended(psus), .proc_stopped(pstop),
	.irq(irq));
txsw_host_model u_host (.core_clk(core_clk), .rst(rst), .word_valid(wv),
	.tx_status_word(word), .host_copy(hcopy), .host_owns(howns));
////////////////////////////////////////////////////////////////////////
task chk(input string n, input logic [31:0] s, input logic [31:0] e);
	tests_run++;
	if (s !== e) begin
		errors++;
		$display("[ERR] %s expected %h seen %h", n, e, s);
	end
endtask
task print_verdict;
	$display("errors %0d tests_run %0d", errors, tests_run);
	if (errors == 0 && tests_run > 0) begin
		$display("== PASSED ==");
	end else begin
		$display("== FAILED ==");
	end
	$finish;
endtask
// Events stand one cycle; the word shows the cycle after
task fire(input logic [10:0] v);
	@(posedge core_clk) ev <= v;
	@(posedge core_clk) ev <= '0;
	#1;
endtask
task fetch(input logic [5:0] d);
	@(posedge core_clk) begin
		dsc <= d;
		dfetch <= 1'b1;
	end
	@(posedge core_clk) dfetch <= 1'b0;
	#1;
endtask
task wr(input logic [3:0] a, input logic [31:0] d);
	@(posedge core_clk) begin
		ra <= a;
		wd <= d;
		rw <= 1'b1;
	end
	@(posedge core_clk) rw <= 1'b0;
endtask
task rd(input logic [3:0] a);
	@(posedge core_clk) begin
		ra <= a;
		rr <= 1'b1;
	end
	@(posedge core_clk) rr <= 1'b0;
	#1 rdv = rdata;
endtask
task wchk(input logic [31:0] e, input logic ab);
	chk("word_valid", {31'h0, wv}, 32'h1);
	chk("frame_abort", {31'h0, fa}, {31'h0, ab});
	chk("word", word, e);
endtask
////////////////////////////////////////////////////////////////////////
task t_under;
	fire(11'h200);
	fire(11'h040);
	wchk(32'h0000_8002, 1'b1);
	chk("suspended", {31'h0, psus}, 32'h1);
	rd(4'h4);
	chk("host_owns", {31'h0, howns}, 32'h1);
	chk("status", rdv, 32'h6);
	rd(4'hc);
	chk("ctrl", rdv, 32'h10);
	chk("irq_masked", {31'h0, irq}, 32'h0);
	wr(4'h8, 32'h7);
	@(posedge core_clk) #1;
	chk("irq", {31'h0, irq}, 32'h1);
	wr(4'h4, 32'h7);
	wr(4'h8, 32'h0);
	@(posedge core_clk) #1;
	chk("irq_cleared", {31'h0, irq}, 32'h0);
	rd(4'h2);
	chk("unmapped", rdv, 32'h0);
	$display("test underrun done");
endtask
task t_babble;
	fire(11'h200);
	fire(11'h100);
	wchk(32'h0000_c000, 1'b1);
	chk("stopped", {31'h0, pstop}, 32'h1);
	rd(4'h4);
	chk("status", rdv, 32'h5);
	wr(4'h4, 32'h7);
	$display("test babble done");
endtask
task t_coll;
	@(posedge core_clk) refl <= 14'h2abc;
	fire(11'h200);
	repeat (15) fire(11'h002);
	chk("early", {31'h0, wv}, 32'h0);
	fire(11'h002);
	chk("abort", {31'h0, fa}, 32'h1);
	chk("word", word & 32'hffff_ff87, 32'h2abc_8100);
	for (int om = 0; om < 2; om++) begin
		wr(4'hc, om);
		fire(11'h200);
		repeat (3) fire(11'h002);
		fire(11'h439);
		wchk(om ? 32'h0000_0099 : 32'h0000_8c99, 1'b0);
	end
	wr(4'hc, 32'h0);
	fire(11'h200);
	fire(11'h004);
	wchk(32'h0000_8200, 1'b1);
	wr(4'h4, 32'h7);
	$display("test collisions done");
endtask
task t_xlate;
	fire(11'h200);
	fire(11'h080);
	chk("refused", {31'h0, wv}, 32'h0);
	@(posedge core_clk) vsel <= 1'b1;
	fire(11'h080);
	wchk(32'h0000_8004, 1'b1);
	chk("suspended", {31'h0, psus}, 32'h1);
	@(posedge core_clk) vsel <= 1'b0;
	wr(4'h4, 32'h7);
	$display("test translation done");
endtask
task t_chain;
	logic [5:0] bad [4];
	bad = '{6'h00, 6'h30, 6'h2c, 6'h22};
	for (int k = 0; k < 4; k++) begin
		fire(11'h200);
		fetch(6'h22);
		fetch(bad[k]);
		wchk(32'h0000_9000, 1'b1);
		chk("suspended", {31'h0, psus}, 32'h1);
		rd(4'h4);
		chk("status", rdv & 32'h2, 32'h2);
		wr(4'h4, 32'h7);
	end
	$display("test chain done");
endtask
task t_freeze;
	logic [31:0] w0;
	w0 = word;
	@(posedge core_clk) ce <= 1'b0;
	fire(11'h040);
	chk("frozen_valid", {31'h0, wv}, 32'h0);
	chk("frozen_word", word, w0);
	@(posedge core_clk) ce <= 1'b1;
	$display("test freeze done");
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	repeat (8) @(posedge core_clk);
	rst <= 1'b0;
	t_under;
	t_babble;
	t_coll;
	t_xlate;
	t_chain;
	t_freeze;
	print_verdict;
end
// All scenarios need well under 2000 cycles
initial begin
	#200000;
	errors++;
	print_verdict;
end
endmodule
`default_nettype wire
